// ---- design/hl_link_cfg.svh ----
// Constants for the host link policy block: clock rate, packet type codes,
// completion status, channel settings and the timing of the shortened link reset.
// Assumes a single 25 MHz clock; included by the policy, training, monitor and bench modules.
`ifndef HL_LINK_CFG_SVH
`define HL_LINK_CFG_SVH

// Clock rate, used to turn times into cycle counts
`define HL_CLK_KHZ 25000
// Shortened link reset hold time, in nanoseconds
`define HL_RST_TIME_NS 1000
// Standard format/type codes of the packet header byte
`define HL_FT_MRD32 8'h00
`define HL_FT_MRD64 8'h20
`define HL_FT_MWR32 8'h40
`define HL_FT_MWR64 8'h60
`define HL_FT_IORD 8'h02
`define HL_FT_IOWR 8'h42
`define HL_FT_CFGRD0 8'h04
`define HL_FT_CFGWR0 8'h44
`define HL_FT_CFGRD1 8'h05
`define HL_FT_CFGWR1 8'h45
`define HL_FT_CPL 8'h0A
`define HL_FT_CPLD 8'h4A
// Message codes: mask drops the routing and data bits, match is the message type
`define HL_FT_MSG_MASK 8'hB8
`define HL_FT_MSG_MATCH 8'h30
// Trusted memory packet codes
`define HL_FT_TMWR 8'h7E
`define HL_FT_TMRD 8'h3E
// Unsupported-request completion status
`define HL_CPL_UR 3'h1
// Virtual channel zero
`define HL_VC0 3'h0
// Number of virtual channels visible to software
`define HL_OS_VC_COUNT 3'h1

`endif

// ---- design/hl_link_pkg.sv ----
// Types shared by the host link policy block.
// Assumes hl_link_cfg.svh is on the include path.
`default_nettype none
package hl_link_pkg;

    // One-hot lane widths
    typedef enum logic [2:0] {
        HL_W1 = 3'h1,
        HL_W2 = 3'h2,
        HL_W4 = 3'h4
    } hl_width_t;

    // One-hot signalling rates: 2.5, 5.0, 8.0 GT/s
    typedef enum logic [2:0] {
        HL_R2P5 = 3'h1,
        HL_R5P0 = 3'h2,
        HL_R8P0 = 3'h4
    } hl_rate_t;

    // Strap set, sampled while reset is held
    typedef struct packed {
        logic [2:0] width_sel;
        logic force_en;
        logic [2:0] force_width;
        logic ac_couple;
        logic half_swing;
    } hl_strap_t;

    // Packet header fields the policy looks at
    typedef struct packed {
        logic [7:0] fmt_type;
        logic [2:0] vc;
        logic [15:0] req_id;
        logic [7:0] tag;
    } hl_hdr_t;

    // Unsupported-request completion
    typedef struct packed {
        logic [15:0] req_id;
        logic [7:0] tag;
        logic [2:0] status;
    } hl_cpl_t;

endpackage

`default_nettype wire

// ---- design/hl_link_policy.sv ----
// Transaction and link policy for the four-lane host link, device end.
// Assumes straps are steady while srst is high and headers arrive one per cycle.
// Every output is registered, and ce low holds every flop.
// Function
// - Link runs at 2.5, 5.0 or 8.0 GT/s, negotiated with the partner.
// - Four, two and one lane widths, chosen by soft strap.
// - Standard width negotiation may narrow the link to two or one lanes.
// - Soft straps can force detection as one, two or four lanes.
// - Trusted memory write and trusted memory read packets are recognised.
// - Channels other than zero stay private, never shown to software.
// - Repeated transaction identifiers are accepted and never flagged as errors.
// - Link reset sequence is shorter than the conventional one.
// - DC coupled by default; strap selects AC; transmitter offers half swing.
// - Device never originates upstream I/O or configuration cycles.
// - No root complex register block; link hidden from the operating system.
// - No lane polarity inversion or lane reversal; lanes wired in order.
`timescale 1ns/1ps
`default_nettype none
`include "hl_link_cfg.svh"

module hl_link_policy (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire hl_link_pkg::hl_strap_t strap_in,
    input wire logic link_reset_req,
    input wire logic [2:0] partner_width_cap,
    input wire logic [2:0] partner_rate_cap,
    input wire logic downsize_req,
    input wire logic [2:0] downsize_width,
    input wire logic rx_valid,
    input wire hl_link_pkg::hl_hdr_t rx_hdr,
    input wire logic up_valid,
    input wire hl_link_pkg::hl_hdr_t up_hdr,
    output logic link_up,
    output hl_link_pkg::hl_width_t link_width,
    output hl_link_pkg::hl_rate_t link_rate,
    output logic [3:0] lane_enable,
    output logic ac_coupled,
    output logic half_swing_en,
    output logic polarity_inv_en,
    output logic lane_reverse_en,
    output logic rcrb_present,
    output logic [2:0] os_vc_count,
    output logic fwd_valid,
    output hl_link_pkg::hl_hdr_t fwd_hdr,
    output logic fwd_trusted,
    output logic cpl_valid,
    output hl_link_pkg::hl_cpl_t cpl_out,
    output logic tx_valid,
    output hl_link_pkg::hl_hdr_t tx_hdr,
    output logic up_refused
);
    import hl_link_pkg::*;

    hl_strap_t strap_reg;
    logic train_up;
    hl_width_t train_width;
    hl_rate_t train_rate;

    // Is this header byte a standard message?
    function automatic logic is_msg(input logic [7:0] ft);
        is_msg = ((ft & `HL_FT_MSG_MASK) == `HL_FT_MSG_MATCH);
    endfunction

    // Is this an I/O or configuration cycle?
    function automatic logic is_io_cfg(input logic [7:0] ft);
        is_io_cfg = (ft == `HL_FT_IORD) || (ft == `HL_FT_IOWR) ||
                    (ft == `HL_FT_CFGRD0) || (ft == `HL_FT_CFGWR0) ||
                    (ft == `HL_FT_CFGRD1) || (ft == `HL_FT_CFGWR1);
    endfunction

    // Is this one of the two trusted memory types?
    function automatic logic is_trusted(input logic [7:0] ft);
        is_trusted = (ft == `HL_FT_TMWR) || (ft == `HL_FT_TMRD);
    endfunction

    // Is this a packet type the link carries at all?
    function automatic logic is_known(input logic [7:0] ft);
        is_known = (ft == `HL_FT_MRD32) || (ft == `HL_FT_MRD64) ||
                   (ft == `HL_FT_MWR32) || (ft == `HL_FT_MWR64) ||
                   (ft == `HL_FT_CPL) || (ft == `HL_FT_CPLD) ||
                   is_msg(ft) || is_io_cfg(ft) || is_trusted(ft);
    endfunction

    // Lanes in use for a width; lane 0 always first, never reordered
    function automatic logic [3:0] lanes_of(input hl_width_t w);
        case (w)
            HL_W4: lanes_of = 4'hF;
            HL_W2: lanes_of = 4'h3;
            default: lanes_of = 4'h1;
        endcase
    endfunction

    // Straps are captured while reset is held, so a strap change later is ignored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strap_reg <= strap_in;
        end
    end

    hl_link_train u_train (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .link_reset_req(link_reset_req),
        .strap(strap_reg),
        .partner_width_cap(partner_width_cap),
        .partner_rate_cap(partner_rate_cap),
        .downsize_req(downsize_req),
        .downsize_width(downsize_width),
        .link_up(train_up),
        .width(train_width),
        .rate(train_rate)
    );

    // Receive classification. Tags are not tracked, so duplicates pass freely
    wire logic rx_take = rx_valid && train_up;
    wire logic rx_known = is_known(rx_hdr.fmt_type);
    // Downstream traffic is expected on channel zero only; anything else is refused
    wire logic rx_vc_ok = (rx_hdr.vc == `HL_VC0);
    wire logic rx_ok = rx_known && rx_vc_ok;
    // Only non-posted requests earn a completion; posted ones and completions just drop
    wire logic rx_np = !is_msg(rx_hdr.fmt_type) && (rx_hdr.fmt_type[6] == 1'b0) &&
                       (rx_hdr.fmt_type != `HL_FT_CPL);
    wire logic rx_ur = rx_take && !rx_ok && rx_np;

    // Next receive outputs; the trusted flag never marks a dropped packet
    wire logic fwd_valid_next = rx_take && rx_ok;
    wire logic fwd_trusted_next = fwd_valid_next && is_trusted(rx_hdr.fmt_type);
    wire hl_cpl_t cpl_next = '{req_id: rx_hdr.req_id, tag: rx_hdr.tag, status: `HL_CPL_UR};

    // Upstream filter: I/O and configuration cycles never leave the device
    wire logic up_take = up_valid && train_up;
    wire logic up_bad = is_io_cfg(up_hdr.fmt_type);
    wire logic tx_valid_next = up_take && !up_bad;
    wire logic up_refused_next = up_valid && (up_bad || !train_up);

    // Lanes follow the trained width in order, and all drop while the link is down
    wire logic [3:0] lane_enable_next = train_up ? lanes_of(train_width) : 4'h0;

    // Link status outputs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link_up <= 1'b0;
            link_width <= HL_W1;
            link_rate <= HL_R2P5;
            lane_enable <= 4'h0;
        end else if (ce) begin
            link_up <= train_up;
            link_width <= train_width;
            link_rate <= train_rate;
            lane_enable <= lane_enable_next;
        end
    end

    // Electrical and software-visible modes; strap copies appear one edge after reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ac_coupled <= 1'b0;
            half_swing_en <= 1'b0;
            polarity_inv_en <= 1'b0;
            lane_reverse_en <= 1'b0;
            rcrb_present <= 1'b0;
            os_vc_count <= `HL_OS_VC_COUNT;
        end else if (ce) begin
            ac_coupled <= strap_reg.ac_couple;
            half_swing_en <= strap_reg.half_swing;
            polarity_inv_en <= 1'b0;
            lane_reverse_en <= 1'b0;
            rcrb_present <= 1'b0;
            os_vc_count <= `HL_OS_VC_COUNT;
        end
    end

    // Forwarded packets; the header is loaded every cycle and valid marks it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fwd_valid <= 1'b0;
            fwd_hdr <= '0;
            fwd_trusted <= 1'b0;
        end else if (ce) begin
            fwd_valid <= fwd_valid_next;
            fwd_hdr <= rx_hdr;
            fwd_trusted <= fwd_trusted_next;
        end
    end

    // Unsupported-request completions for refused non-posted packets
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cpl_valid <= 1'b0;
            cpl_out <= '0;
        end else if (ce) begin
            cpl_valid <= rx_ur;
            cpl_out <= cpl_next;
        end
    end

    // Upstream packets; private channels pass on the wire but are never counted above
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_valid <= 1'b0;
            tx_hdr <= '0;
        end else if (ce) begin
            tx_valid <= tx_valid_next;
            tx_hdr <= up_hdr;
        end
    end

    // Refusal pulse, also raised for anything offered while the link is down
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            up_refused <= 1'b0;
        end else if (ce) begin
            up_refused <= up_refused_next;
        end
    end

endmodule

`default_nettype wire

// ---- design/hl_link_train.sv ----
// Width and rate training for the host link, with the shortened reset.
// Assumes partner capabilities are steady while training is under way.
`timescale 1ns/1ps
`default_nettype none
`include "hl_link_cfg.svh"

module hl_link_train (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic link_reset_req,
    input wire hl_link_pkg::hl_strap_t strap,
    input wire logic [2:0] partner_width_cap,
    input wire logic [2:0] partner_rate_cap,
    input wire logic downsize_req,
    input wire logic [2:0] downsize_width,
    output logic link_up,
    output hl_link_pkg::hl_width_t width,
    output hl_link_pkg::hl_rate_t rate
);
    import hl_link_pkg::*;

    localparam int RST_CYC_RAW = (`HL_RST_TIME_NS * `HL_CLK_KHZ + 999999) / 1000000;
    localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;

    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_DETECT = 4'h2,
        ST_NEGOT = 4'h4,
        ST_ACTIVE = 4'h8
    } hl_train_st_t;

    // Highest one-hot bit common to both sets, lowest bit as fallback
    function automatic logic [2:0] hi_common(input logic [2:0] a, input logic [2:0] b);
        logic [2:0] c;
        c = a & b;
        if (c[2]) begin
            hi_common = 3'h4;
        end else if (c[1]) begin
            hi_common = 3'h2;
        end else begin
            hi_common = 3'h1;
        end
    endfunction

    hl_train_st_t st_reg, st_next;
    logic [7:0] cnt_reg;
    hl_width_t width_reg;
    hl_rate_t rate_reg;

    // Width limit below which the partner is allowed to train
    wire logic [2:0] width_limit = strap.force_en ? strap.force_width : strap.width_sel;
    // A forced width detects as that width alone; otherwise the partner may narrow it
    wire logic [2:0] width_cand = strap.force_en ? strap.force_width
        : hi_common(3'h7 >> (width_limit[2] ? 0 : (width_limit[1] ? 1 : 2)),
                    partner_width_cap);
    wire logic [2:0] rate_cand = hi_common(3'h7, partner_rate_cap);
    wire logic narrower = (downsize_width < width_reg) && (downsize_width != 3'h0);
    wire logic cnt_done = (cnt_reg == 8'(RST_CYC - 1));

    // Next state of training
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_RESET: if (cnt_done) st_next = ST_DETECT;
            ST_DETECT: st_next = ST_NEGOT;
            ST_NEGOT: st_next = ST_ACTIVE;
            ST_ACTIVE: if (link_reset_req) st_next = ST_RESET;
            default: st_next = ST_RESET;
        endcase
    end

    // Short reset counter; keeps the reset hold brief
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg <= 8'h00;
        end else if (ce) begin
            cnt_reg <= (st_reg == ST_RESET && !cnt_done) ? cnt_reg + 8'h01 : 8'h00;
        end
    end

    // State, width and rate registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= ST_RESET;
            width_reg <= HL_W1;
            rate_reg <= HL_R2P5;
        end else if (ce) begin
            st_reg <= st_next;
            if (st_reg == ST_NEGOT) begin
                width_reg <= hl_width_t'(width_cand);
                rate_reg <= hl_rate_t'(rate_cand);
            end else if (st_reg == ST_ACTIVE && downsize_req && narrower) begin
                width_reg <= hl_width_t'(hi_common(downsize_width, 3'h3));
            end
        end
    end

    assign link_up = (st_reg == ST_ACTIVE);
    assign width = width_reg;
    assign rate = rate_reg;

endmodule

`default_nettype wire

// ---- tb/hl_link_monitor.sv ----
// Port checker for the host link policy block.
// Bound to hl_link_policy; assumes ce stays high while the link trains after srst.
`timescale 1ns/1ps
`default_nettype none
`include "hl_link_cfg.svh"

module hl_link_monitor (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic rx_valid,
    input wire hl_link_pkg::hl_hdr_t rx_hdr,
    input wire logic up_valid,
    input wire hl_link_pkg::hl_hdr_t up_hdr,
    input wire logic link_up,
    input wire hl_link_pkg::hl_width_t link_width,
    input wire logic [3:0] lane_enable,
    input wire logic polarity_inv_en,
    input wire logic lane_reverse_en,
    input wire logic rcrb_present,
    input wire logic [2:0] os_vc_count,
    input wire logic fwd_valid,
    input wire hl_link_pkg::hl_hdr_t fwd_hdr,
    input wire logic fwd_trusted,
    input wire logic cpl_valid,
    input wire hl_link_pkg::hl_cpl_t cpl_out,
    input wire logic tx_valid,
    input wire logic up_refused
);
    import hl_link_pkg::*;
    wire logic [3:0] exp_lanes;
    wire logic io_cfg;
    wire logic rx_ok;
    wire logic is_tr;
    // Decodes; link_up output lags the internal state, so it gates safely except in the cycle after the link drops
    assign exp_lanes = (link_width == HL_W4) ? 4'hF : (link_width == HL_W2) ? 4'h3 : 4'h1;
    assign io_cfg = up_hdr.fmt_type inside {`HL_FT_IORD, `HL_FT_IOWR, `HL_FT_CFGRD0,
        `HL_FT_CFGWR0, `HL_FT_CFGRD1, `HL_FT_CFGWR1};
    assign rx_ok = ce && rx_valid && link_up;
    assign is_tr = rx_hdr.fmt_type == `HL_FT_TMWR || rx_hdr.fmt_type == `HL_FT_TMRD;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_lane_fixed: assert property (!polarity_inv_en && !lane_reverse_en)
        else $error("lane inversion or reversal enabled");
    chk_no_rcrb: assert property (!rcrb_present && os_vc_count == `HL_OS_VC_COUNT)
        else $error("link exposed to software");
    // Lanes match the width while up and are all off while down
    chk_lane_map: assert property (lane_enable == (link_up ? exp_lanes : 4'h0))
        else $error("lanes do not match width");
    chk_trusted_gate: assert property (fwd_trusted |-> fwd_valid)
        else $error("trusted flag on a dropped packet");
    chk_io_refused: assert property (ce && up_valid && io_cfg |=> up_refused && !tx_valid)
        else $error("upstream io or config cycle sent");
    chk_trusted_fwd: assert property (rx_ok && rx_hdr.vc == `HL_VC0 && is_tr
        |=> fwd_valid && fwd_trusted) else $error("trusted packet not forwarded");
    chk_dup_accept: assert property (rx_ok && rx_hdr.vc == `HL_VC0
        && rx_hdr.fmt_type == `HL_FT_MWR32 |=> fwd_valid && !cpl_valid && fwd_hdr == $past(rx_hdr))
        else $error("posted write not forwarded");
    chk_ur_cpl: assert property (rx_ok && rx_hdr.vc != `HL_VC0
        && rx_hdr.fmt_type == `HL_FT_MRD32 |=> cpl_valid && cpl_out.status == `HL_CPL_UR
        && cpl_out.tag == $past(rx_hdr.tag)) else $error("missing unsupported completion");
    chk_short_reset: assert property ($fell(srst) |-> !link_up ##[1:40] link_up)
        else $error("link training too long");

    cover property (rx_ok && is_tr);
    cover property (cpl_valid);
    cover property (up_refused);
    cover property (link_up && link_width == HL_W1);
endmodule

bind hl_link_policy hl_link_monitor u_hl_link_monitor (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .rx_valid(rx_valid), .rx_hdr(rx_hdr), .up_valid(up_valid), .up_hdr(up_hdr),
    .link_up(link_up), .link_width(link_width), .lane_enable(lane_enable),
    .polarity_inv_en(polarity_inv_en), .lane_reverse_en(lane_reverse_en),
    .rcrb_present(rcrb_present), .os_vc_count(os_vc_count), .fwd_valid(fwd_valid),
    .fwd_hdr(fwd_hdr), .fwd_trusted(fwd_trusted), .cpl_valid(cpl_valid),
    .cpl_out(cpl_out), .tx_valid(tx_valid), .up_refused(up_refused));
`default_nettype wire

// ---- tb/hl_link_partner.sv ----
// Processor-side link port model: capabilities and downstream headers.
// Assumes the bench commands each header; all outputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none

module hl_link_partner (
    input wire logic ref_clk,
    input wire logic send,
    input wire hl_link_pkg::hl_hdr_t hdr,
    input wire logic [2:0] wcap,
    input wire logic [2:0] rcap,
    output logic rx_valid,
    output hl_link_pkg::hl_hdr_t rx_hdr,
    output logic [2:0] width_cap,
    output logic [2:0] rate_cap
);
    import hl_link_pkg::*;
    initial begin
        rx_valid = 1'b0;
        rx_hdr = '0;
        width_cap = 3'h7;
        rate_cap = 3'h7;
    end
    // Offered widths and rates; lanes wired straight with true polarity
    always @(negedge ref_clk) begin
        width_cap <= wcap;
        rate_cap <= rcap;
    end
    // One header a cycle; idle data inverts so a stale header is never reused
    always @(negedge ref_clk) begin
        rx_valid <= send;
        rx_hdr <= send ? hdr : ~rx_hdr;
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for hl_link_policy with the processor port model.
// Drives ce and the link reset request itself; the partner supplies received headers.
`timescale 1ns/1ps
`default_nettype none
`include "hl_link_cfg.svh"

module testbench;
    import hl_link_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic p_send = 1'b0;
    logic ce = 1'b1;
    logic link_reset_req = 1'b0;
    logic downsize_req = 1'b0;
    logic up_valid = 1'b0;
    logic [2:0] downsize_width = 3'h0;
    logic [2:0] p_wcap = 3'h7;
    logic [2:0] p_rcap = 3'h7;
    hl_strap_t strap = '0;
    hl_hdr_t p_hdr = '0;
    hl_hdr_t up_hdr = '0;
    hl_hdr_t rx_hdr, fwd_hdr, tx_hdr;
    hl_cpl_t cpl_out;
    hl_width_t link_width;
    hl_rate_t link_rate;
    logic [2:0] wcap, rcap, os_vc_count;
    logic [3:0] lane_enable;
    logic rx_valid, link_up, ac_coupled, half_swing_en, polarity_inv_en, lane_reverse_en;
    logic rcrb_present, fwd_valid, fwd_trusted, cpl_valid, tx_valid, up_refused;
    int error_cnt = 0;
    int n_compared = 0;

    always #20 ref_clk = ~ref_clk;

    hl_link_policy u_hl_link_policy (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .strap_in(strap), .link_reset_req(link_reset_req), .partner_width_cap(wcap),
        .partner_rate_cap(rcap), .downsize_req(downsize_req), .downsize_width(downsize_width),
        .rx_valid(rx_valid), .rx_hdr(rx_hdr), .up_valid(up_valid), .up_hdr(up_hdr),
        .link_up(link_up), .link_width(link_width), .link_rate(link_rate),
        .lane_enable(lane_enable), .ac_coupled(ac_coupled), .half_swing_en(half_swing_en),
        .polarity_inv_en(polarity_inv_en), .lane_reverse_en(lane_reverse_en),
        .rcrb_present(rcrb_present), .os_vc_count(os_vc_count), .fwd_valid(fwd_valid),
        .fwd_hdr(fwd_hdr), .fwd_trusted(fwd_trusted), .cpl_valid(cpl_valid),
        .cpl_out(cpl_out), .tx_valid(tx_valid), .tx_hdr(tx_hdr), .up_refused(up_refused));

    hl_link_partner u_hl_link_partner (.ref_clk(ref_clk), .send(p_send), .hdr(p_hdr),
        .wcap(p_wcap), .rcap(p_rcap), .rx_valid(rx_valid), .rx_hdr(rx_hdr),
        .width_cap(wcap), .rate_cap(rcap));

    task automatic print_verdict();
        $display("compared %0d, wrong %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp_vec(logic [34:0] got, logic [34:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Reset with a strap set, then wait a bounded time for training
    task automatic train_case(hl_strap_t s, logic [2:0] wc, logic [2:0] rc, hl_width_t ew,
        hl_rate_t er);
        int n;
        n = 0;
        @(negedge ref_clk);
        srst = 1'b1;
        strap = s;
        p_wcap = wc;
        p_rcap = rc;
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        while (link_up !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        cmp_vec(n <= 40, 1'h1);
        if (n >= 60) print_verdict();
        cmp_vec(link_width, ew);
        cmp_vec(link_rate, er);
        cmp_vec(lane_enable, ew == HL_W4 ? 4'hF : ew == HL_W2 ? 4'h3 : 4'h1);
        cmp_vec({ac_coupled, half_swing_en}, {s.ac_couple, s.half_swing});
        cmp_vec({rcrb_present, os_vc_count}, {1'h0, `HL_OS_VC_COUNT});
        cmp_vec({polarity_inv_en, lane_reverse_en}, 2'h0);
    endtask

    // Partner link reset: link drops, refuses upstream traffic, retrains at the strap width
    task automatic lr_check(hl_width_t ew);
        int n;
        n = 0;
        @(negedge ref_clk);
        link_reset_req = 1'b1;
        @(negedge ref_clk);
        link_reset_req = 1'b0;
        up_valid = 1'b1;
        up_hdr = {`HL_FT_MWR32, 3'h0, 16'h0201, 8'h09};
        @(negedge ref_clk);
        cmp_vec({link_up, lane_enable, tx_valid, up_refused}, 7'h01);
        up_valid = 1'b0;
        while (link_up !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        cmp_vec(n <= 40, 1'h1);
        if (n >= 60) print_verdict();
        cmp_vec(link_width, ew);
    endtask

    // Clock enable low: an offered upstream packet is not taken and link state holds
    task automatic ce_check();
        @(negedge ref_clk);
        ce = 1'b0;
        up_valid = 1'b1;
        up_hdr = {`HL_FT_MWR32, 3'h0, 16'h0201, 8'h0A};
        repeat (3) @(negedge ref_clk);
        cmp_vec({link_up, tx_valid, up_refused}, 3'h4);
        up_valid = 1'b0;
        ce = 1'b1;
    endtask

    // Narrow a trained link; width output lands two edges after the request
    task automatic ds_check(logic [2:0] w, hl_width_t ew);
        @(negedge ref_clk);
        downsize_req = 1'b1;
        downsize_width = w;
        @(negedge ref_clk);
        downsize_req = 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp_vec({link_width, lane_enable}, {ew, ew == HL_W2 ? 4'h3 : 4'h1});
    endtask

    // Partner sends one header n cycles back to back; each answer checked
    task automatic rx_check(hl_hdr_t h, logic f, logic t, logic c, int n);
        @(posedge ref_clk);
        p_send = 1'b1;
        p_hdr = h;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            if (i == n - 1) p_send = 1'b0;
            @(negedge ref_clk);
            cmp_vec({fwd_valid, fwd_trusted, cpl_valid}, {f, t, c});
            if (f) cmp_vec(fwd_hdr, h);
            if (c) cmp_vec(cpl_out, {h.req_id, h.tag, `HL_CPL_UR});
        end
    endtask

    // Device-originated upstream header; answer checked one cycle on
    task automatic up_check(logic [7:0] f, logic ok);
        @(negedge ref_clk);
        up_valid = 1'b1;
        up_hdr = {f, 3'h0, 16'h0201, f};
        @(negedge ref_clk);
        cmp_vec({tx_valid, up_refused}, {ok, !ok});
        if (ok) cmp_vec(tx_hdr, up_hdr);
        up_valid = 1'b0;
    endtask

    localparam logic [7:0] UP_CODES [8] = '{`HL_FT_IORD, `HL_FT_IOWR, `HL_FT_CFGRD0,
        `HL_FT_CFGWR0, `HL_FT_CFGRD1, `HL_FT_CFGWR1, `HL_FT_MWR32, `HL_FT_MRD32};

    // Hang guard: counts as a mismatch
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        train_case({3'h2, 1'h0, 3'h0, 2'h0}, 3'h7, 3'h3, HL_W2, HL_R5P0);
        train_case({3'h4, 1'h1, 3'h1, 2'h1}, 3'h7, 3'h1, HL_W1, HL_R2P5);
        train_case({3'h1, 1'h1, 3'h2, 2'h2}, 3'h7, 3'h7, HL_W2, HL_R8P0);
        train_case({3'h4, 1'h0, 3'h0, 2'h3}, 3'h3, 3'h6, HL_W2, HL_R8P0);
        train_case({3'h4, 1'h0, 3'h0, 2'h0}, 3'h7, 3'h7, HL_W4, HL_R8P0);
        ds_check(3'h2, HL_W2);
        ds_check(3'h1, HL_W1);
        lr_check(HL_W4);
        rx_check({`HL_FT_MRD32, 3'h0, 16'h1234, 8'h05}, 1'b1, 1'b0, 1'b0, 1);
        rx_check({`HL_FT_TMWR, 3'h0, 16'h0042, 8'h06}, 1'b1, 1'b1, 1'b0, 1);
        rx_check({`HL_FT_TMRD, 3'h0, 16'h0042, 8'h07}, 1'b1, 1'b1, 1'b0, 1);
        rx_check({`HL_FT_MWR32, 3'h0, 16'hBEEF, 8'h11}, 1'b1, 1'b0, 1'b0, 2);
        rx_check({`HL_FT_MRD32, 3'h1, 16'h00A5, 8'h3C}, 1'b0, 1'b0, 1'b1, 1);
        rx_check({`HL_FT_TMRD, 3'h2, 16'h0042, 8'h08}, 1'b0, 1'b0, 1'b1, 1);
        rx_check({8'h7F, 3'h0, 16'h0033, 8'h21}, 1'b0, 1'b0, 1'b0, 1);
        for (int i = 0; i < 8; i++) up_check(UP_CODES[i], i >= 6);
        ce_check();
        print_verdict();
    end
endmodule
`default_nettype wire
